/* rtl/flash_command_control.sv */
// flash command register and configuration register front end
// assumes: one peripheral clock, array sequencer reports done, bus reads
// take one cycle and return data the cycle after the request
`timescale 1ns/10ps
`default_nettype none
`include "flash_command_control_defines.svh"

module flash_command_control (
    input  wire logic                                 clk,
    input  wire logic                                 reset,
    input  wire flash_command_control_pkg::reg_req_s  regReq,
    output logic [31:0]                               regRdata,
    input  wire logic                                 writeProtect,
    input  wire logic                                 sysBusBusy,
    input  wire logic                                 arrayBusy,
    input  wire logic                                 arrayDone,
    input  wire logic                                 securitySet,
    input  wire logic                                 userRowAddr,
    input  wire logic                                 pageBufLastWord,
    output flash_command_control_pkg::array_op_e      arrayOp,
    output logic                                      arrayStart,
    output logic                                      pageBufClear,
    output logic                                      cacheFlush,
    output logic                                      powerReduced,
    output logic                                      ready,
    output logic                                      programmingError,
    output flash_command_control_pkg::flash_cfg_s     flashCfg,
    output logic                                      missWaitState,
    output logic                                      cacheEnable
);

    flash_command_control_pkg::ctrl_state_s cur;
    flash_command_control_pkg::ctrl_state_s next_cur;

    logic        wrCmd;
    logic        wrCfg;
    logic        keyWritten;
    logic [7:0]  keyVal;
    logic [6:0]  codeVal;
    logic        cmdOk;
    flash_command_control_pkg::array_op_e decodedOp;

    // ======================================================================
    // register decode
    // RULE3: writes blocked under protection
    assign wrCmd = regReq.sel && regReq.write && !writeProtect && (regReq.addr == `CMDREG_OFFSET);
    assign wrCfg = regReq.sel && regReq.write && !writeProtect && (regReq.addr == `FLASHCFG_OFFSET);
    // RULE7: key counts whenever its own lane 1 is written, with or without the code lane
    assign keyWritten = wrCmd && regReq.byteEn[1];
    assign keyVal     = regReq.wdata[`KEY_MSB:`KEY_LSB];
    // RULE11: code from current write if lane 0 present
    assign codeVal = regReq.byteEn[0] ? regReq.wdata[`CMD_CODE_MSB:`CMD_CODE_LSB] : cur.cmdCode;

    // ======================================================================
    // command decode
    // RULE12: to RULE20 mapping; RULE27 reserved codes refused
    always_comb begin
        decodedOp = flash_command_control_pkg::OP_NONE;
        cmdOk     = 1'b1;
        case (codeVal)
            // RULE12: erase row
            `CMD_ERASE_ROW:     decodedOp = flash_command_control_pkg::OP_ERASE_ROW;
            // RULE13: write page
            `CMD_WRITE_PAGE:    decodedOp = flash_command_control_pkg::OP_WRITE_PAGE;
            // RULE14: aux erase guarded
            `CMD_ERASE_AUX: begin
                decodedOp = flash_command_control_pkg::OP_ERASE_AUX;
                cmdOk     = !securitySet && userRowAddr;
            end
            // RULE15: aux write guarded
            `CMD_WRITE_AUX: begin
                decodedOp = flash_command_control_pkg::OP_WRITE_AUX;
                cmdOk     = !securitySet && userRowAddr;
            end
            // RULE16: region lock and unlock
            `CMD_LOCK_REGION:   decodedOp = flash_command_control_pkg::OP_LOCK;
            `CMD_UNLOCK_REGION: decodedOp = flash_command_control_pkg::OP_UNLOCK;
            // RULE19: security via lock row
            `CMD_SET_SECURITY:  decodedOp = flash_command_control_pkg::OP_SET_SECURITY;
            `CMD_ENTER_PR, `CMD_LEAVE_PR, `CMD_PB_CLEAR, `CMD_CACHE_FLUSH: begin
                decodedOp = flash_command_control_pkg::OP_NONE;
            end
            // RULE27: reserved code is an error
            default:            cmdOk = 1'b0;
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        next_cur            = cur;
        next_cur.opStart    = 1'b0;
        next_cur.pbClear    = 1'b0;
        next_cur.cacheFlush = 1'b0;

        // RULE2: byte lanes of configuration
        if (wrCfg) begin
            for (int b = 0; b < 4; b++) begin
                if (regReq.byteEn[b]) begin
                    // mask lane cut to eight bits so reserved bits never store
                    next_cur.cfg[b*8 +: 8] = regReq.wdata[b*8 +: 8] & 8'(`CFG_WRITE_MASK >> (b*8));
                end
            end
        end
        if (wrCmd && regReq.byteEn[0]) begin
            next_cur.cmdCode = regReq.wdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
        end

        case (cur.state)
            flash_command_control_pkg::ST_PENDING: begin
                // RULE8: system bus has priority
                if (!sysBusBusy && !arrayBusy) begin
                    next_cur.keyPending = 1'b0;
                    if (cur.op != flash_command_control_pkg::OP_NONE) begin
                        next_cur.opStart = 1'b1;
                        next_cur.state   = flash_command_control_pkg::ST_BUSY;
                        next_cur.cacheFlush = 1'b1;
                    end else begin
                        next_cur.state = flash_command_control_pkg::ST_IDLE;
                        case (cur.cmdCode)
                            // RULE17: power reduction
                            `CMD_ENTER_PR:    next_cur.powerReduced = 1'b1;
                            `CMD_LEAVE_PR:    next_cur.powerReduced = 1'b0;
                            // RULE18: page buffer clear
                            `CMD_PB_CLEAR:    next_cur.pbClear = 1'b1;
                            // RULE20: cache flush
                            `CMD_CACHE_FLUSH: next_cur.cacheFlush = 1'b1;
                            default:          next_cur.state = flash_command_control_pkg::ST_IDLE;
                        endcase
                    end
                end
            end
            flash_command_control_pkg::ST_BUSY: begin
                if (arrayDone) begin
                    next_cur.state = flash_command_control_pkg::ST_IDLE;
                    next_cur.op    = flash_command_control_pkg::OP_NONE;
                end
            end
            flash_command_control_pkg::ST_IDLE: begin
                // RULE23: automatic page write
                if (!cur.cfg[`CFG_MANUAL_BIT] && pageBufLastWord) begin
                    next_cur.op    = flash_command_control_pkg::OP_WRITE_PAGE;
                    next_cur.state = flash_command_control_pkg::ST_PENDING;
                end
            end
            default: next_cur.state = flash_command_control_pkg::ST_IDLE;
        endcase

        // RULE4: key accept
        if (keyWritten) begin
            if (keyVal != `EXEC_KEY) begin
                // RULE5: bad key flags error
                next_cur.progError = 1'b1;
            end else if (cur.state != flash_command_control_pkg::ST_IDLE) begin
                // RULE6: busy flags error
                next_cur.progError = 1'b1;
            end else if (!cmdOk) begin
                next_cur.progError = 1'b1;
            end else begin
                // RULE10: key bit held until issue
                next_cur.keyPending = 1'b1;
                next_cur.op         = decodedOp;
                next_cur.progError  = 1'b0;
                next_cur.state      = flash_command_control_pkg::ST_PENDING;
            end
        end

        // RULE1: single cycle read of any size
        next_cur.rdata = 32'h00000000;
        if (regReq.sel && !regReq.write) begin
            case (regReq.addr)
                // RULE21: bit 7 zero; RULE10 key bit 0
                `CMDREG_OFFSET:   next_cur.rdata = {16'h0000, 7'h00, cur.keyPending, 1'b0, cur.cmdCode};
                // RULE22: upper bits zero by mask
                `FLASHCFG_OFFSET: next_cur.rdata = cur.cfg & `CFG_WRITE_MASK;
                default:          next_cur.rdata = 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            cur            <= '0;
            cur.state      <= flash_command_control_pkg::ST_IDLE;
            cur.op         <= flash_command_control_pkg::OP_NONE;
            cur.cmdCode    <= 7'(`CMDREG_RESET);
            cur.cfg        <= `FLASHCFG_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ======================================================================
    // outputs
    assign regRdata         = cur.rdata;
    assign arrayOp          = cur.op;
    assign arrayStart       = cur.opStart;
    assign pageBufClear     = cur.pbClear;
    assign cacheFlush       = cur.cacheFlush;
    assign powerReduced     = cur.powerReduced;
    // RULE9: ready tells software when to issue
    assign ready            = (cur.state == flash_command_control_pkg::ST_IDLE);
    assign programmingError = cur.progError;
    // RULE24: wait state field
    assign flashCfg.readWaitStates      = cur.cfg[`CFG_WAIT_MSB:`CFG_WAIT_LSB];
    assign flashCfg.manualWrite         = cur.cfg[`CFG_MANUAL_BIT];
    assign flashCfg.sleepPowerReduction = cur.cfg[`CFG_SLEEP_MSB:`CFG_SLEEP_LSB];
    assign flashCfg.cacheOff            = cur.cfg[`CFG_CACHEOFF_BIT];
    assign flashCfg.cacheReadPolicy     = cur.cfg[`CFG_POLICY_MSB:`CFG_POLICY_LSB];
    // RULE25: cache enable
    assign cacheEnable   = !cur.cfg[`CFG_CACHEOFF_BIT];
    // RULE26: one extra wait on miss in low power policy
    assign missWaitState = (cur.cfg[`CFG_POLICY_MSB:`CFG_POLICY_LSB] == `POLICY_LOW_POWER);

    // ======================================================================
    // checks
    chk_bad_key_error: assert property (@(posedge clk) disable iff (reset) // RULE5
        keyWritten && keyVal != `EXEC_KEY |=> programmingError && !arrayStart)
        else $error("bad key did not flag error");
    chk_busy_error: assert property (@(posedge clk) disable iff (reset) // RULE6
        keyWritten && !ready |=> programmingError)
        else $error("command during busy not flagged");
    chk_protect_block: assert property (@(posedge clk) disable iff (reset) // RULE3
        regReq.sel && regReq.write && writeProtect |=> $stable(cur.cfg) && $stable(cur.cmdCode))
        else $error("write went through protection");
    chk_bus_priority: assert property (@(posedge clk) disable iff (reset) // RULE8
        sysBusBusy |=> !arrayStart)
        else $error("command started over bus access");
    chk_key_readback: assert property (@(posedge clk) disable iff (reset) // RULE10
        cur.keyPending |-> cur.state == flash_command_control_pkg::ST_PENDING)
        else $error("key bit set without pending command");
    chk_good_key_go: assert property (@(posedge clk) disable iff (reset) // RULE4
        keyWritten && keyVal == `EXEC_KEY && ready && cmdOk |=> cur.keyPending)
        else $error("valid key not accepted");
    chk_cfg_reserved: assert property (@(posedge clk) disable iff (reset) // RULE22
        (cur.cfg & ~`CFG_WRITE_MASK) == 32'h00000000)
        else $error("reserved configuration bit set");
    chk_reserved_code: assert property (@(posedge clk) disable iff (reset) // RULE27
        keyWritten && keyVal == `EXEC_KEY && ready && !cmdOk |=> programmingError && ready)
        else $error("reserved code not refused");

endmodule // flash_command_control
`default_nettype wire

/* rtl/flash_command_control_defines.svh */
// constants for the flash command and configuration front end
// assumes: included by bare name from the design module
// ==========================================================================
// Notes on behaviour
// RULE1: registers accept single atomic byte, halfword and word accesses.
// RULE2: every byte lane and halfword of a register is reachable directly.
// RULE3: writes are ignored while access protection is on.
// RULE4: commands run only with execution key 0xa5; software must supply it.
// RULE5: wrong key means no command and programming error flag set.
// RULE6: new command while one is busy sets programming error flag.
// RULE7: software writes key and command code in one access.
// RULE8: system bus flash access wins; command waits until bus and array idle.
// RULE9: software issues commands only while ready reads one.
// RULE10: key bit 0 reads one until the command is issued, then zero.
// RULE11: command code is seven bits in low byte, selects executed command.
// RULE12: code 0x2 erases the addressed row.
// RULE13: code 0x4 programs page buffer into addressed main page.
// RULE14: code 0x5 erases aux row; only unsecured, user row only.
// RULE15: code 0x6 writes aux page; only unsecured, user row only.
// RULE16: codes 0x40 and 0x41 lock and unlock the addressed region.
// RULE17: codes 0x42 and 0x43 enter and leave power reduction.
// RULE18: code 0x44 clears the whole page buffer.
// RULE19: code 0x45 sets security by zeroing lock row first byte.
// RULE20: code 0x46 invalidates every read cache line.
// RULE21: command register bit 7 always reads zero.
// RULE22: configuration bits 31 down to 19 always read zero.
// RULE23: manual write zero lets last page buffer word start a page write.
// RULE24: four-bit read wait state field, zero to fifteen, resets zero.
// RULE25: cache off bit one disables the read cache.
// RULE26: read policy 0 no miss penalty, 1 one miss wait, 2 deterministic.
// RULE27: reserved code with valid key changes nothing, flags programming error. The code still stores the reserved code in the command code field.
`ifndef FLASH_COMMAND_CONTROL_DEFINES_SVH
`define FLASH_COMMAND_CONTROL_DEFINES_SVH

// ==========================================================================
// register offsets (byte addresses)
`define CMDREG_OFFSET      6'h00
`define FLASHCFG_OFFSET    6'h04
`define CMDREG_RESET       16'h0000
`define FLASHCFG_RESET     32'h00000000

// ==========================================================================
// field positions
`define CMD_CODE_LSB       0
`define CMD_CODE_MSB       6
`define KEY_LSB            8
`define KEY_MSB            15
`define CFG_WAIT_LSB       1
`define CFG_WAIT_MSB       4
`define CFG_MANUAL_BIT     7
`define CFG_SLEEP_LSB      8
`define CFG_SLEEP_MSB      9
`define CFG_POLICY_LSB     16
`define CFG_POLICY_MSB     17
`define CFG_CACHEOFF_BIT   18
// writable bits of the configuration register
`define CFG_WRITE_MASK     32'h0007039e

// ==========================================================================
// key and command codes
`define EXEC_KEY           8'ha5
`define CMD_ERASE_ROW      7'h02
`define CMD_WRITE_PAGE     7'h04
`define CMD_ERASE_AUX      7'h05
`define CMD_WRITE_AUX      7'h06
`define CMD_LOCK_REGION    7'h40
`define CMD_UNLOCK_REGION  7'h41
`define CMD_ENTER_PR       7'h42
`define CMD_LEAVE_PR       7'h43
`define CMD_PB_CLEAR       7'h44
`define CMD_SET_SECURITY   7'h45
`define CMD_CACHE_FLUSH    7'h46

// ==========================================================================
// read policy codes
`define POLICY_NO_PENALTY  2'h0
`define POLICY_LOW_POWER   2'h1
`define POLICY_DETERMINE   2'h2

`endif

/* rtl/flash_command_control_pkg.sv */
// types shared by the flash command front end
// assumes: compiled before the design module
package flash_command_control_pkg;

    // operation handed to the array sequencer
    typedef enum logic [3:0] {
        OP_NONE, OP_ERASE_ROW, OP_WRITE_PAGE, OP_ERASE_AUX, OP_WRITE_AUX,
        OP_LOCK, OP_UNLOCK, OP_SET_SECURITY
    } array_op_e;

    typedef enum logic [1:0] {
        ST_IDLE, ST_PENDING, ST_BUSY
    } ctrl_state_e;

    // register bus request
    typedef struct packed {
        logic        sel;
        logic        write;
        logic [5:0]  addr;
        logic [3:0]  byteEn;
        logic [31:0] wdata;
    } reg_req_s;

    // configuration outputs
    typedef struct packed {
        logic       manualWrite;
        logic [3:0] readWaitStates;
        logic [1:0] sleepPowerReduction;
        logic       cacheOff;
        logic [1:0] cacheReadPolicy;
    } flash_cfg_s;

    // whole module state
    typedef struct packed {
        ctrl_state_e state;
        logic [6:0]  cmdCode;
        logic        keyPending;
        logic [31:0] cfg;
        logic        progError;
        logic        powerReduced;
        array_op_e   op;
        logic        opStart;
        logic        pbClear;
        logic        cacheFlush;
        logic [31:0] rdata;
    } ctrl_state_s;

endpackage

/* sim/flash_array_model.sv */
// far side model: flash array that answers a start with busy, then done
// assumes: shares the clock and reset of the command front end
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic arrayStart,
    input  wire logic slow,
    output logic      arrayBusy,
    output logic      arrayDone
);
    // ==========================================================
    // busy countdown
    logic [5:0] left;
    // a slow array leaves room for a second command while busy
    always @(posedge clk) begin
        arrayDone <= 1'b0;
        if (reset) begin
            left      <= 6'h00;
            arrayBusy <= 1'b0;
        end else if (arrayStart) begin
            left      <= slow ? 6'h14 : 6'h02;
            arrayBusy <= 1'b1;
        end else if (arrayBusy) begin
            left <= left - 6'h01;
            if (left == 6'h01) begin
                arrayBusy <= 1'b0;
                arrayDone <= 1'b1;
            end
        end
    end
endmodule // flash_array_model
`default_nettype wire

/* sim/tb_flash_command_control.sv */
// bench for the flash command front end: register calls with expected values
// assumes: array model on the far side, inputs driven 1 ns after each edge
`timescale 1ns/10ps
`default_nettype none
module tb_flash_command_control;
    // ==========================================================
    // signals
    logic clk, reset, writeProtect, sysBusBusy, arrayBusy, arrayDone, securitySet;
    logic userRowAddr, pageBufLastWord, arrayStart, pageBufClear, cacheFlush, slow;
    logic powerReduced, ready, programmingError, missWaitState, cacheEnable;
    logic [31:0] regRdata, startCnt, clrCnt, flushCnt;
    flash_command_control_pkg::reg_req_s   regReq;
    flash_command_control_pkg::array_op_e  arrayOp, lastOp;
    flash_command_control_pkg::flash_cfg_s flashCfg;
    int error_cnt, check_count, i;
    logic [6:0] codes [7] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h40, 7'h41, 7'h45};
    logic [3:0] ops [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

    flash_command_control DUT (.clk(clk), .reset(reset), .regReq(regReq), .regRdata(regRdata),
        .writeProtect(writeProtect), .sysBusBusy(sysBusBusy), .arrayBusy(arrayBusy),
        .arrayDone(arrayDone), .securitySet(securitySet), .userRowAddr(userRowAddr),
        .pageBufLastWord(pageBufLastWord), .arrayOp(arrayOp), .arrayStart(arrayStart),
        .pageBufClear(pageBufClear), .cacheFlush(cacheFlush), .powerReduced(powerReduced),
        .ready(ready), .programmingError(programmingError), .flashCfg(flashCfg),
        .missWaitState(missWaitState), .cacheEnable(cacheEnable));
    flash_array_model farSide (.clk(clk), .reset(reset), .arrayStart(arrayStart), .slow(slow),
        .arrayBusy(arrayBusy), .arrayDone(arrayDone));

    // ==========================================================
    // pulse counters, so one-cycle outputs are never missed
    always @(posedge clk) begin
        if (arrayStart) begin
            startCnt <= startCnt + 32'h1;
            lastOp   <= arrayOp;
        end
        if (pageBufClear) clrCnt <= clrCnt + 32'h1;
        if (cacheFlush) flushCnt <= flushCnt + 32'h1;
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one access per taken edge, request held until that edge
    task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        regReq = '{1'b1, w, a, be, d};
        step(1);
        regReq.sel = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        acc(1'b0, a, 4'hf, 32'h0);
        chk(regRdata, exp);
    endtask
    task automatic clr;
        startCnt = 32'h0;
        clrCnt = 32'h0;
        flushCnt = 32'h0;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        if (n == 300) begin
            error_cnt++;
            finish_test;
        end
    endtask
    // key and code in one write next only once ready
    task automatic cmd(input logic [6:0] c, input logic [7:0] k);
        clr;
        acc(1'b1, 6'h00, 4'h3, {16'h0, k, 1'b0, c});
        // pulses leave the front end one edge later and are counted one more edge on
        step(2);
        wait_ready;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {reset, writeProtect, sysBusBusy, securitySet, pageBufLastWord, slow} = 6'h20;
        userRowAddr = 1'b1;
        regReq = '0;
        error_cnt = 0;
        check_count = 0;
        clr;
        step(8);
        reset = 1'b0;
        chk({ready, programmingError, powerReduced, cacheEnable}, 32'h9);
        rd(6'h00, 32'h0);
        rd(6'h04, 32'h0);
        acc(1'b1, 6'h04, 4'hf, 32'hffffffff);
        rd(6'h04, 32'h0007039e);
        chk({21'h0, flashCfg, cacheEnable}, 32'h7fe);
        acc(1'b1, 6'h04, 4'h4, 32'h00010000);
        rd(6'h04, 32'h0001039e);
        chk({missWaitState, cacheEnable}, 32'h3);
        acc(1'b1, 6'h04, 4'h3, 32'h00000012);
        rd(6'h04, 32'h00010012);
        writeProtect = 1'b1;
        acc(1'b1, 6'h04, 4'hf, 32'h0);
        rd(6'h04, 32'h00010012);
        writeProtect = 1'b0;
        acc(1'b1, 6'h00, 4'h1, 32'h000000ff);
        rd(6'h00, 32'h0000007f);
        // automatic page write on the last buffer word
        clr;
        pageBufLastWord = 1'b1;
        step(1);
        pageBufLastWord = 1'b0;
        step(2);
        wait_ready;
        chk({startCnt[27:0], lastOp}, 32'h12);
        acc(1'b1, 6'h04, 4'h1, 32'h00000080);
        clr;
        pageBufLastWord = 1'b1;
        step(1);
        pageBufLastWord = 1'b0;
        step(3);
        chk(startCnt, 32'h0);
        // refused keys leave the buffer alone
        cmd(7'h44, 8'ha4);
        chk({clrCnt[30:0], programmingError}, 32'h1);
        cmd(7'h44, 8'ha6);
        chk({clrCnt[30:0], programmingError}, 32'h1);
        cmd(7'h44, 8'ha5);
        chk({clrCnt[30:0], programmingError}, 32'h2);
        cmd(7'h42, 8'ha5);
        chk(powerReduced, 1'b1);
        cmd(7'h43, 8'ha5);
        chk(powerReduced, 1'b0);
        cmd(7'h46, 8'ha5);
        chk(flushCnt, 32'h1);
        // every array command once
        for (i = 0; i < 7; i++) begin
            cmd(codes[i], 8'ha5);
            chk({startCnt[26:0], lastOp, programmingError}, {27'h1, ops[i], 1'b0});
        end
        securitySet = 1'b1;
        cmd(7'h05, 8'ha5);
        chk({startCnt[30:0], programmingError}, 32'h1);
        securitySet = 1'b0;
        userRowAddr = 1'b0;
        cmd(7'h06, 8'ha5);
        chk({startCnt[30:0], programmingError}, 32'h1);
        userRowAddr = 1'b1;
        cmd(7'h03, 8'ha5);
        chk({startCnt[30:0], programmingError}, 32'h1);
        // system bus access holds the command back
        clr;
        sysBusBusy = 1'b1;
        acc(1'b1, 6'h00, 4'h3, 32'h0000a502);
        step(4);
        chk(startCnt, 32'h0);
        rd(6'h00, 32'h00000102);
        sysBusBusy = 1'b0;
        wait_ready;
        chk(startCnt, 32'h1);
        rd(6'h00, 32'h00000002);
        // second command while the slow array is busy
        slow = 1'b1;
        clr;
        acc(1'b1, 6'h00, 4'h3, 32'h0000a502);
        step(4);
        acc(1'b1, 6'h00, 4'h3, 32'h0000a544);
        step(1);
        chk({clrCnt[30:0], programmingError}, 32'h1);
        wait_ready;
        slow = 1'b0;
        finish_test;
    end
endmodule // tb_flash_command_control
`default_nettype wire
